// >>> can_ctl_pkg.sv
// constants, register map and mode codes of the mode and status block
// assumes a 32-bit apb slave with one aligned word per 16-bit register
// Summary of operation
// - mode 111 enters listen-all, errors ignored
// - listen-all error copies partial assembly to receive
// - loopback ties internal transmit to internal receive
// - loopback releases transmit and receive pins
// - mode request codes; 101 and 110 reserved
// - current mode read-only, resets to configuration
// - abort-all aborts pending, self-clears when done
// - stop-in-idle halts module while chip idles
// - capture enable makes capture event per reception
// - window select picks filter or buffer window
// - data compare bit count read-only, 18+ invalid
// - matched filter number 0 to 15 read-only
// - interrupt code identifies highest pending source
// - buffer-size code maps to buffer count
// - fifo start buffer index 0 to 31
// - fifo write pointer read-only six bits
// - fifo read pointer read-only six bits
// - error-state status bits, warning is either warning
// - error flag set by error-state conditions
// - event flags set by hardware, cleared by software
// - mode changes only once bus idle seen
// - configuration registers writable only in configuration mode
package can_ctl_pkg;
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_DISABLE = 3'h1,
    MODE_LOOPBACK = 3'h2,
    MODE_LISTEN_ONLY = 3'h3,
    MODE_CONFIG = 3'h4,
    MODE_RSVD_A = 3'h5,
    MODE_RSVD_B = 3'h6,
    MODE_LISTEN_ALL = 3'h7
  } mode_e;

  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_VECTOR = 8'h08;
  localparam logic [7:0] OFS_FIFO_CTRL = 8'h0c;
  localparam logic [7:0] OFS_FIFO_PTR = 8'h10;
  localparam logic [7:0] OFS_INT_FLAGS = 8'h14;

  localparam int BIT_STOP_IDLE = 13;
  localparam int BIT_ABORT = 12;
  localparam int POS_REQ_MODE = 8;
  localparam int POS_CUR_MODE = 5;
  localparam int BIT_CAPTURE = 3;
  localparam int BIT_WINDOW = 0;
  localparam int POS_FILTER_HIT = 8;
  localparam int POS_DMA_SIZE = 13;
  localparam int POS_WR_PTR = 8;
  localparam int POS_ERR_STATE = 8;

  localparam int FLG_TX_BUF = 0;
  localparam int FLG_RX_BUF = 1;
  localparam int FLG_RX_OVF = 2;
  localparam int FLG_FIFO = 3;
  localparam int FLG_ERROR = 5;
  localparam int FLG_WAKE = 6;
  localparam int FLG_INVALID = 7;
  localparam logic [7:0] FLAG_MASK = 8'hef;

  localparam mode_e RST_MODE = MODE_CONFIG;
  localparam logic [4:0] DATA_COMPARE_BIT_COUNT_LAST_VALID = 5'h11;
  localparam logic [4:0] FILTER_LAST = 5'h0f;

  localparam logic [6:0] CODE_NONE = 7'h40;
  localparam logic [6:0] CODE_ERROR = 7'h41;
  localparam logic [6:0] CODE_WAKE = 7'h42;
  localparam logic [6:0] CODE_OVERFLOW = 7'h43;
  localparam logic [6:0] CODE_FIFO = 7'h44;

  function automatic logic [5:0] dma_count(input logic [2:0] code);
    case (code)
      3'h0: dma_count = 6'h04;
      3'h1: dma_count = 6'h06;
      3'h2: dma_count = 6'h08;
      3'h3: dma_count = 6'h0c;
      3'h4: dma_count = 6'h10;
      3'h5: dma_count = 6'h18;
      3'h6: dma_count = 6'h20;
      default: dma_count = 6'h00;
    endcase
  endfunction : dma_count
endpackage : can_ctl_pkg

// >>> interrupt_source_code_if.sv
// carries flags, enables and buffer events to the interrupt code encoder
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface interrupt_source_code_if #(parameter int NUM_BUF = 16);
  logic [7:0] flags;
  logic [7:0] enables;
  logic [NUM_BUF-1:0] buf_pending;
  logic [6:0] code;
  modport src (output flags, output enables, output buf_pending, input code);
  modport enc (input flags, input enables, input buf_pending, output code);
endinterface : interrupt_source_code_if
`default_nettype wire

// >>> interrupt_source_code_encoder.sv
// interrupt code priority encoder
// assumes flag and enable bits laid out as in the package
`timescale 1ns/1ps
`default_nettype none
module interrupt_source_code_encoder #(
  parameter int NUM_BUF = 16
) (
  interrupt_source_code_if.enc port
);
  if (NUM_BUF < 1 || NUM_BUF > 16) begin : g_bad_num_buf
    $error("buffer count out of range");
  end

  logic [7:0] live;
  assign live = port.flags & port.enables;

  always_comb begin
    port.code = can_ctl_pkg::CODE_NONE;
    for (int i = NUM_BUF - 1; i >= 0; i--) begin
      if (port.buf_pending[i] && ((i < 8) ? live[can_ctl_pkg::FLG_TX_BUF]
          || live[can_ctl_pkg::FLG_RX_BUF] : live[can_ctl_pkg::FLG_RX_BUF])) begin
        port.code = 7'(i);
      end
    end
    if (live[can_ctl_pkg::FLG_FIFO]) begin
      port.code = can_ctl_pkg::CODE_FIFO;
    end
    if (live[can_ctl_pkg::FLG_WAKE]) begin
      port.code = can_ctl_pkg::CODE_WAKE;
    end
    if (live[can_ctl_pkg::FLG_RX_OVF]) begin
      port.code = can_ctl_pkg::CODE_OVERFLOW;
    end
    if (live[can_ctl_pkg::FLG_ERROR]) begin
      port.code = can_ctl_pkg::CODE_ERROR;
    end
  end
endmodule : interrupt_source_code_encoder
`default_nettype wire

// >>> can_mode_status_control.sv
// mode request, pin routing, status and flag registers of a can controller
// assumes the protocol engine and buffer logic share ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module can_mode_status_control #(
  parameter int NUM_BUF = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic bus_idle_i,
  input wire logic tx_busy_i,
  input wire logic tx_pending_i,
  input wire logic chip_idle_i,
  input wire logic core_tx_i,
  input wire logic can_rx_pin_i,
  output logic can_tx_pin_o,
  output logic tx_pin_owned_o,
  output logic rx_pin_owned_o,
  output logic core_rx_o,
  output logic tx_allowed_o,
  output logic ignore_errors_o,
  input wire logic frame_error_i,
  output logic copy_partial_o,
  output logic abort_all_tx_o,
  output logic module_run_o,
  input wire logic rx_done_i,
  output logic capture_event_o,
  output logic register_window_select_o,
  output logic config_write_enable_o,
  output logic [5:0] dma_buffer_count_o,
  output logic [4:0] fifo_start_buffer_o,
  input wire logic [4:0] data_compare_bit_count_i,
  input wire logic [4:0] matched_filter_number_i,
  input wire logic [5:0] fifo_write_pointer_i,
  input wire logic [5:0] fifo_read_pointer_i,
  input wire logic tx_bus_off_i,
  input wire logic tx_error_passive_i,
  input wire logic rx_error_passive_i,
  input wire logic tx_error_warning_i,
  input wire logic rx_error_warning_i,
  input wire logic invalid_message_i,
  input wire logic wakeup_activity_i,
  input wire logic fifo_almost_full_i,
  input wire logic rx_overflow_i,
  input wire logic rx_buffer_i,
  input wire logic tx_buffer_i,
  input wire logic [NUM_BUF-1:0] buf_pending_i,
  input wire logic [7:0] int_enable_i,
  output logic [6:0] interrupt_source_code_o
);
  if (NUM_BUF < 1 || NUM_BUF > 16) begin : g_bad_num_buf
    $error("buffer count out of range");
  end

  // control state
  logic stop_in_idle;
  logic abort_all_tx;
  can_ctl_pkg::mode_e requested_mode;
  can_ctl_pkg::mode_e current_mode;
  logic rx_capture_enable;
  logic register_window_select;
  logic [2:0] dma_size_code;
  logic [4:0] fifo_start_buffer;
  logic [7:0] flags;
  logic [5:0] err_state;
  logic [5:0] err_state_prev;
  logic rx_meta;
  logic rx_sync;

  // bus decode
  logic wr_en;
  logic rd_setup;
  logic hit;
  logic [15:0] rd_word;

  assign wr_en = psel_i & penable_i & pwrite_i & clk_en_i;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i & clk_en_i;
  assign pready_o = psel_i & penable_i & clk_en_i;

  always_comb begin
    hit = 1'b1;
    if (paddr_i == can_ctl_pkg::OFS_CTRL_ONE) begin
      rd_word = {2'h0, stop_in_idle, abort_all_tx, 1'b0, requested_mode,
                 current_mode, 1'b0, rx_capture_enable, 2'h0,
                 register_window_select};
    end else if (paddr_i == can_ctl_pkg::OFS_CTRL_TWO) begin
      rd_word = {11'h000, data_compare_bit_count_i};
    end else if (paddr_i == can_ctl_pkg::OFS_VECTOR) begin
      rd_word = {3'h0, matched_filter_number_i, 1'b0,
                 interrupt_source_code_o};
    end else if (paddr_i == can_ctl_pkg::OFS_FIFO_CTRL) begin
      rd_word = {dma_size_code, 8'h00, fifo_start_buffer};
    end else if (paddr_i == can_ctl_pkg::OFS_FIFO_PTR) begin
      rd_word = {2'h0, fifo_write_pointer_i, 2'h0, fifo_read_pointer_i};
    end else if (paddr_i == can_ctl_pkg::OFS_INT_FLAGS) begin
      rd_word = {2'h0, err_state, flags & can_ctl_pkg::FLAG_MASK};
    end else begin
      hit = 1'b0;
      rd_word = 16'h0000;
    end
  end

  assign pslverr_o = pready_o & ~hit;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_o <= {16'h0000, rd_word};
    end
  end

  logic wr_ctrl_one;
  logic wr_fifo_ctrl;
  logic wr_flags;
  assign wr_ctrl_one = wr_en && paddr_i == can_ctl_pkg::OFS_CTRL_ONE;
  assign wr_fifo_ctrl = wr_en && paddr_i == can_ctl_pkg::OFS_FIFO_CTRL;
  assign wr_flags = wr_en && paddr_i == can_ctl_pkg::OFS_INT_FLAGS;

  // mode request register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      stop_in_idle <= 1'b0;
      requested_mode <= can_ctl_pkg::RST_MODE;
      rx_capture_enable <= 1'b0;
      register_window_select <= 1'b0;
    end else if (clk_en_i && wr_ctrl_one) begin
      stop_in_idle <= pwdata_i[can_ctl_pkg::BIT_STOP_IDLE];
      rx_capture_enable <= pwdata_i[can_ctl_pkg::BIT_CAPTURE];
      register_window_select <= pwdata_i[can_ctl_pkg::BIT_WINDOW];
      if (pwdata_i[can_ctl_pkg::POS_REQ_MODE +: 3] != can_ctl_pkg::MODE_RSVD_A &&
          pwdata_i[can_ctl_pkg::POS_REQ_MODE +: 3] != can_ctl_pkg::MODE_RSVD_B) begin
        requested_mode <= can_ctl_pkg::mode_e'(pwdata_i[can_ctl_pkg::POS_REQ_MODE +: 3]);
      end
    end
  end

  // abort request, set by software, cleared once nothing is pending
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      abort_all_tx <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_ctrl_one && pwdata_i[can_ctl_pkg::BIT_ABORT]) begin
        abort_all_tx <= 1'b1;
      end else if (abort_all_tx && !tx_pending_i) begin
        abort_all_tx <= 1'b0;
      end
    end
  end

  // mode acknowledge at bus idle; configuration waits for no transmission
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      current_mode <= can_ctl_pkg::RST_MODE;
    end else if (clk_en_i && requested_mode != current_mode && bus_idle_i) begin
      if (requested_mode != can_ctl_pkg::MODE_CONFIG || !tx_busy_i) begin
        current_mode <= requested_mode;
      end
    end
  end

  // fifo sizing, locked outside configuration mode
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      dma_size_code <= 3'h0;
      fifo_start_buffer <= 5'h00;
    end else if (clk_en_i && wr_fifo_ctrl && config_write_enable_o) begin
      if (pwdata_i[can_ctl_pkg::POS_DMA_SIZE +: 3] != 3'h7) begin
        dma_size_code <= pwdata_i[can_ctl_pkg::POS_DMA_SIZE +: 3];
      end
      fifo_start_buffer <= pwdata_i[4:0];
    end
  end

  assign config_write_enable_o = current_mode == can_ctl_pkg::MODE_CONFIG;
  assign dma_buffer_count_o = can_ctl_pkg::dma_count(dma_size_code);
  assign fifo_start_buffer_o = fifo_start_buffer;
  assign register_window_select_o = register_window_select;
  assign abort_all_tx_o = abort_all_tx;

  // error state status, warning when either side warns
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      err_state <= 6'h00;
      err_state_prev <= 6'h00;
    end else if (clk_en_i) begin
      err_state <= {tx_bus_off_i, tx_error_passive_i, rx_error_passive_i,
                    tx_error_warning_i, rx_error_warning_i,
                    tx_error_warning_i | rx_error_warning_i};
      err_state_prev <= err_state;
    end
  end

  // event flags: hardware sets, software writes zero to clear, set wins
  logic [7:0] set_flags;
  logic [7:0] clr_flags;
  always_comb begin
    set_flags = 8'h00;
    set_flags[can_ctl_pkg::FLG_INVALID] = invalid_message_i;
    set_flags[can_ctl_pkg::FLG_WAKE] = wakeup_activity_i;
    set_flags[can_ctl_pkg::FLG_ERROR] = |(err_state & ~err_state_prev)
                                        && current_mode != can_ctl_pkg::MODE_LISTEN_ALL;
    set_flags[can_ctl_pkg::FLG_FIFO] = fifo_almost_full_i;
    set_flags[can_ctl_pkg::FLG_RX_OVF] = rx_overflow_i;
    set_flags[can_ctl_pkg::FLG_RX_BUF] = rx_buffer_i;
    set_flags[can_ctl_pkg::FLG_TX_BUF] = tx_buffer_i;
    clr_flags = wr_flags ? ~pwdata_i[7:0] : 8'h00;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flags <= 8'h00;
    end else if (clk_en_i) begin
      flags <= ((flags & ~clr_flags) | set_flags) & can_ctl_pkg::FLAG_MASK;
    end
  end

  // receive pin synchroniser
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else if (clk_en_i) begin
      rx_meta <= can_rx_pin_i;
      rx_sync <= rx_meta;
    end
  end

  logic loopback;
  logic listen_all;
  logic online;
  assign loopback = current_mode == can_ctl_pkg::MODE_LOOPBACK;
  assign listen_all = current_mode == can_ctl_pkg::MODE_LISTEN_ALL;
  assign online = current_mode != can_ctl_pkg::MODE_CONFIG &&
                  current_mode != can_ctl_pkg::MODE_DISABLE;

  // pin ownership and routing
  assign tx_pin_owned_o = current_mode == can_ctl_pkg::MODE_NORMAL;
  assign rx_pin_owned_o = online && !loopback;
  assign core_rx_o = loopback ? core_tx_i : rx_sync;
  assign can_tx_pin_o = tx_pin_owned_o ? core_tx_i : 1'b1;
  assign tx_allowed_o = tx_pin_owned_o || loopback;
  assign ignore_errors_o = listen_all;
  assign module_run_o = !(stop_in_idle && chip_idle_i);

  // one-cycle event pulses
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      copy_partial_o <= 1'b0;
      capture_event_o <= 1'b0;
    end else if (clk_en_i) begin
      copy_partial_o <= listen_all && frame_error_i;
      capture_event_o <= rx_capture_enable && rx_done_i;
    end
  end

  // interrupt code
  interrupt_source_code_if #(.NUM_BUF(NUM_BUF)) code_bus ();
  assign code_bus.flags = flags;
  assign code_bus.enables = int_enable_i & can_ctl_pkg::FLAG_MASK;
  assign code_bus.buf_pending = buf_pending_i;

  interrupt_source_code_encoder #(.NUM_BUF(NUM_BUF)) u_interrupt_source_code (
    .port(code_bus.enc)
  );

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      interrupt_source_code_o <= can_ctl_pkg::CODE_NONE;
    end else if (clk_en_i) begin
      interrupt_source_code_o <= code_bus.code;
    end
  end
endmodule : can_mode_status_control
`default_nettype wire

// >>> can_ctl_asserts.sv
// port-level checks of the mode and status block
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module can_ctl_asserts (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic bus_idle_i,
  input wire logic tx_pending_i,
  input wire logic chip_idle_i,
  input wire logic core_tx_i,
  input wire logic can_tx_pin_o,
  input wire logic tx_pin_owned_o,
  input wire logic rx_pin_owned_o,
  input wire logic core_rx_o,
  input wire logic tx_allowed_o,
  input wire logic ignore_errors_o,
  input wire logic frame_error_i,
  input wire logic copy_partial_o,
  input wire logic abort_all_tx_o,
  input wire logic module_run_o,
  input wire logic rx_done_i,
  input wire logic capture_event_o,
  input wire logic config_write_enable_o,
  input wire logic [6:0] interrupt_source_code_o
);
  logic wr;
  assign wr = psel_i && penable_i && pwrite_i && clk_en_i;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  listen_all_a:
    assert property (ignore_errors_o |-> !tx_pin_owned_o && !tx_allowed_o)
    else $error("listen-all drives the bus");
  copy_on_error_a:
    assert property (frame_error_i && ignore_errors_o && clk_en_i |=> copy_partial_o)
    else $error("no copy after error");
  copy_cause_a:
    assert property ($past(clk_en_i) && copy_partial_o |-> $past(frame_error_i && ignore_errors_o))
    else $error("copy without error");
  loop_route_a:
    assert property (tx_allowed_o && !tx_pin_owned_o |-> core_rx_o == core_tx_i && !rx_pin_owned_o)
    else $error("loopback route wrong");
  tx_release_a:
    assert property (!tx_pin_owned_o |-> can_tx_pin_o)
    else $error("released pin not recessive");
  abort_set_a:
    assert property ($rose(abort_all_tx_o) |-> $past(wr && paddr_i == 8'h00 && pwdata_i[12]))
    else $error("abort set without write");
  abort_clear_a:
    assert property (abort_all_tx_o && !tx_pending_i && clk_en_i && !(wr && pwdata_i[12])
      |=> !abort_all_tx_o)
    else $error("abort not cleared");
  idle_run_a:
    assert property (!chip_idle_i |-> module_run_o)
    else $error("halted outside idle");
  capture_a:
    assert property ($past(clk_en_i) && capture_event_o |-> $past(rx_done_i))
    else $error("capture without reception");
  code_legal_a:
    assert property (interrupt_source_code_o inside {[7'h00:7'h0f], [7'h40:7'h44]})
    else $error("reserved interrupt code");
  mode_idle_a:
    assert property ($changed(config_write_enable_o) || $changed(ignore_errors_o)
      |-> $past(bus_idle_i))
    else $error("mode changed on busy bus");
endmodule : can_ctl_asserts
bind can_mode_status_control can_ctl_asserts chk (.ref_clk_i, .rst_i, .clk_en_i, .paddr_i,
  .psel_i, .penable_i, .pwrite_i, .pwdata_i, .bus_idle_i, .tx_pending_i, .chip_idle_i, .core_tx_i,
  .can_tx_pin_o, .tx_pin_owned_o, .rx_pin_owned_o, .core_rx_o, .tx_allowed_o, .ignore_errors_o,
  .frame_error_i, .copy_partial_o, .abort_all_tx_o, .module_run_o, .rx_done_i, .capture_event_o,
  .config_write_enable_o, .interrupt_source_code_o);
`default_nettype wire

// >>> can_node_model.sv
// other nodes on the bus: one frame per request, then eleven recessive bits
// assumes one bit per ref_clk_i cycle
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic bad_i,
  output logic can_rx_o,
  output logic bus_idle_o,
  output logic frame_error_o,
  output logic rx_done_o
);
  logic [5:0] cnt;
  logic bad;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt <= 6'h00;
      bad <= 1'b0;
    end else if (start_i && cnt == 6'h00) begin
      cnt <= 6'h1b;
      bad <= bad_i;
    end else if (cnt != 6'h00) begin
      cnt <= cnt - 6'h01;
    end
  end
  assign can_rx_o = (cnt > 6'h0b) ? cnt[0] ^ cnt[2] : 1'b1;
  assign bus_idle_o = (cnt == 6'h00);
  assign frame_error_o = (cnt == 6'h0c) && bad;
  assign rx_done_o = (cnt == 6'h0c) && !bad;
endmodule : can_node_model
`default_nettype wire

// >>> tb_top.sv
// self-checking bench of the mode and status block
// assumes the register offsets of can_ctl_pkg and the bus node model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk_i, rst_i, clk_en_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, serr;
  logic bus_idle_i, tx_busy_i, tx_pending_i, chip_idle_i, core_tx_i, can_rx_pin_i, go, bad;
  logic can_tx_pin_o, tx_pin_owned_o, rx_pin_owned_o, core_rx_o, tx_allowed_o, ignore_errors_o;
  logic frame_error_i, copy_partial_o, abort_all_tx_o, module_run_o, rx_done_i, capture_event_o;
  logic register_window_select_o, config_write_enable_o, tx_bus_off_i, tx_error_passive_i;
  logic rx_error_passive_i, tx_error_warning_i, rx_error_warning_i, invalid_message_i;
  logic wakeup_activity_i, fifo_almost_full_i, rx_overflow_i, rx_buffer_i, tx_buffer_i;
  logic [7:0] paddr_i, int_enable_i, flg;
  logic [31:0] pwdata_i, prdata_o, seed, rd, v;
  logic [5:0] dma_buffer_count_o, fifo_write_pointer_i, fifo_read_pointer_i, set_ev;
  logic [4:0] fifo_start_buffer_o, data_compare_bit_count_i, matched_filter_number_i, err, e, f;
  logic [15:0] buf_pending_i;
  logic [6:0] interrupt_source_code_o;
  logic [2:0] cur, sz;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int caps = 0;
  int copies = 0;
  logic [2:0] modes [6] = '{3'h2, 3'h7, 3'h3, 3'h1, 3'h0, 3'h4};
  logic [6:0] codes [5] = '{7'h41, 7'h43, 7'h42, 7'h44, 7'h03};
  int order [4] = '{5, 2, 6, 3};
  logic [5:0] bufs [8] = '{6'h04, 6'h06, 6'h08, 6'h0c, 6'h10, 6'h18, 6'h20, 6'h00};
  assign {tx_bus_off_i, tx_error_passive_i, rx_error_passive_i} = err[4:2];
  assign {tx_error_warning_i, rx_error_warning_i} = err[1:0];
  assign {invalid_message_i, wakeup_activity_i, fifo_almost_full_i} = set_ev[5:3];
  assign {rx_overflow_i, rx_buffer_i, tx_buffer_i} = set_ev[2:0];
  can_mode_status_control #(.NUM_BUF(16)) DUT (.*);
  can_node_model peer (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .start_i(go), .bad_i(bad),
    .can_rx_o(can_rx_pin_i), .bus_idle_o(bus_idle_i), .frame_error_o(frame_error_i),
    .rx_done_o(rx_done_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    core_tx_i <= seed[7] ^ cycles[0];
    caps <= caps + 32'(capture_event_o === 1'b1);
    copies <= copies + 32'(copy_partial_o === 1'b1);
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [15:0] ctl1(input logic s, a, input logic [2:0] q, m, input logic c, w);
    return {2'h0, s, a, 1'b0, q, m, 1'b0, c, 2'h0, w};
  endfunction : ctl1
  function automatic logic [5:0] pins(input logic [2:0] m, input logic t);
    return {m == 3'h0, !(m inside {3'h1, 3'h2, 3'h4}), m == 3'h0 || m == 3'h2, m == 3'h7,
      m == 3'h4, m != 3'h0 || t};
  endfunction : pins
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {16'h0, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    serr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [15:0] x);
    apb(1'b0, a, 16'h0);
    chk(rd, {16'h0, x});
  endtask : rdchk
  initial begin
    seed = 32'h9e58;
    {rst_i, clk_en_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = {2'b11, 43'h0};
    {tx_busy_i, tx_pending_i, chip_idle_i, go, bad, err, set_ev} = 16'h0;
    {buf_pending_i, int_enable_i, data_compare_bit_count_i, matched_filter_number_i} = 34'h0;
    {fifo_write_pointer_i, fifo_read_pointer_i} = 12'h0;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rdchk(8'h00, ctl1(1'b0, 1'b0, 3'h4, 3'h4, 1'b0, 1'b0));
    rdchk(8'h08, 16'h0040);
    cur = 3'h4;
    foreach (modes[i]) begin
      go <= 1'b1;
      bad <= (cur == 3'h7);
      @(posedge ref_clk_i);
      go <= 1'b0;
      apb(1'b1, 8'h00, ctl1(1'b0, 1'b0, modes[i], 3'h7, 1'b1, modes[i][0]));
      rdchk(8'h00, ctl1(1'b0, 1'b0, modes[i], cur, 1'b1, modes[i][0]));
      while (bus_idle_i !== 1'b1) @(posedge ref_clk_i);
      @(posedge ref_clk_i);
      cur = modes[i];
      rdchk(8'h00, ctl1(1'b0, 1'b0, cur, cur, 1'b1, cur[0]));
      chk(32'(register_window_select_o), 32'(cur[0]));
      chk(32'({tx_pin_owned_o, rx_pin_owned_o, tx_allowed_o, ignore_errors_o,
        config_write_enable_o, can_tx_pin_o}), 32'(pins(cur, core_tx_i)));
      if (cur == 3'h2) chk(32'(core_rx_o), 32'(core_tx_i));
    end
    chk(caps, 5);
    chk(copies, 1);
    for (int m = 5; m < 7; m++) begin
      apb(1'b1, 8'h00, ctl1(1'b0, 1'b0, 3'(m), 3'h0, 1'b0, 1'b0));
      rdchk(8'h00, ctl1(1'b0, 1'b0, 3'h4, 3'h4, 1'b0, 1'b0));
    end
    for (int c = 0; c < 8; c++) begin
      v = rnd();
      f = (c == 0) ? 5'h1f : (c == 7) ? f : v[4:0];
      apb(1'b1, 8'h0c, {3'(c), 8'h00, f});
      if (c < 7) sz = 3'(c);
      rdchk(8'h0c, {sz, 8'h00, f});
      chk(32'(dma_buffer_count_o), 32'(bufs[sz]));
      chk(32'(fifo_start_buffer_o), 32'(f));
    end
    apb(1'b1, 8'h00, 16'h0000);
    apb(1'b1, 8'h0c, {3'h1, 8'h00, ~f});
    rdchk(8'h0c, {sz, 8'h00, f});
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'hffdf1 : rnd();
      data_compare_bit_count_i <= 5'(v[4:0] % 18);
      matched_filter_number_i <= {1'b0, v[8:5]};
      fifo_write_pointer_i <= {1'b0, v[14:10]};
      fifo_read_pointer_i <= {1'b0, v[19:15]};
      @(posedge ref_clk_i);
      rdchk(8'h04, 16'(v[4:0] % 18));
      rdchk(8'h08, {4'h0, v[8:5], 8'h40});
      rdchk(8'h10, {3'h0, v[14:10], 3'h0, v[19:15]});
    end
    matched_filter_number_i <= 5'h00;
    int_enable_i <= 8'hef;
    buf_pending_i <= 16'h0208;
    v = rnd();
    e = v[4:0] | 5'h01;
    err <= e;
    set_ev <= 6'h3f;
    @(posedge ref_clk_i);
    set_ev <= 6'h00;
    repeat (3) @(posedge ref_clk_i);
    flg = 8'hef;
    rdchk(8'h14, {2'h0, e, e[1] | e[0], flg});
    foreach (codes[i]) begin
      rdchk(8'h08, {9'h000, codes[i]});
      if (i < 4) flg[order[i]] = 1'b0;
      apb(1'b1, 8'h14, {8'hff, flg});
    end
    apb(1'b1, 8'h14, 16'h0000);
    apb(1'b1, 8'h14, 16'hffff);
    rdchk(8'h14, {2'h0, e, e[1] | e[0], 8'h00});
    rdchk(8'h08, 16'h0040);
    tx_pending_i <= 1'b1;
    apb(1'b1, 8'h00, ctl1(1'b0, 1'b1, 3'h0, 3'h0, 1'b0, 1'b0));
    rdchk(8'h00, ctl1(1'b0, 1'b1, 3'h0, 3'h0, 1'b0, 1'b0));
    chk(32'(abort_all_tx_o), 32'h1);
    tx_pending_i <= 1'b0;
    @(posedge ref_clk_i);
    rdchk(8'h00, 16'h0000);
    chip_idle_i <= 1'b1;
    @(posedge ref_clk_i);
    chk(32'(module_run_o), 32'h1);
    apb(1'b1, 8'h00, ctl1(1'b1, 1'b0, 3'h0, 3'h0, 1'b0, 1'b0));
    chk(32'(module_run_o), 32'h0);
    chip_idle_i <= 1'b0;
    clk_en_i <= 1'b0;
    set_ev <= 6'h01;
    @(posedge ref_clk_i);
    clk_en_i <= 1'b1;
    set_ev <= 6'h00;
    rdchk(8'h14, {2'h0, e, e[1] | e[0], 8'h00});
    apb(1'b0, 8'h18, 16'h0000);
    chk({rd[31:1], serr}, 32'h1);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
